// *** cbc_pkg.sv ***
package cbc_pkg;
  // Register byte offsets inside the 4 KiB window
  localparam logic [11:0] ADDR_SELECT  = 12'h000;
  localparam logic [11:0] ADDR_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_BYTE    = 12'h008;
  localparam logic [11:0] ADDR_RESULT  = 12'h00c;
  localparam logic [7:0]  ADDR_MAP_HI  = 8'h00;

  // Field layout
  localparam int SEL_W        = 4;
  localparam int SEL_RSV_BIT  = 3;
  localparam int BYTE_W       = 8;
  localparam int CRC_W        = 16;
  localparam int HOLD_BIT     = 0;
  localparam int LEVEL_LSB    = 8;

  // Reset values
  localparam logic [3:0]  SEL_RESET  = 4'h4;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [15:0] CRC_RESET  = 16'hffff;
  localparam logic        HOLD_RESET = 1'b0;

  // Buffering
  localparam int FIFO_DEPTH = 8;

  // Preset table, entry n is algorithm code n
  localparam logic [7:0][15:0] ALG_POLY = {
    16'h1021, 16'h1021, 16'h1021, 16'h1021,
    16'h8005, 16'h8005, 16'h8005, 16'h8005};
  localparam logic [7:0][15:0] ALG_INIT = {
    16'h0000, 16'hffff, 16'hffff, 16'h0000,
    16'hffff, 16'hffff, 16'h0000, 16'h0000};
  localparam logic [7:0][15:0] ALG_XOR = {
    16'h0000, 16'hffff, 16'h0000, 16'h0000,
    16'h0000, 16'hffff, 16'hffff, 16'h0000};
  // One bit per code: input and output reflection together
  localparam logic [7:0]       ALG_REFL = 8'h5f;
endpackage : cbc_pkg

// *** cbc_top.sv ***
`timescale 1ns/1ps
// Operation
// - each data write feeds one low byte
// - four-bit selector picks presets zero to seven
// - codes 0-3 use 0x8005, reflected, listed init/xor
// - codes 4-7 use 0x1021 with listed parameters
// - polynomial has implicit leading x^16 term
// - selector write loads algorithm initial value
// - reflected algorithms reverse each input byte
// - reflected algorithms reverse remainder before xor
// - result is remainder xored with constant
// - remainder updated by modulo-2 byte division
// - data register at 0x08, byte in 7:0
// - result register at 0x0C, value in 15:0
// - selector resets to four
// - result resets 0xFFFF, data register zero

// Byte queue between the bus and the CRC engine
module cbc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_in_valid,
  output logic                      o_in_ready,
  input  wire logic [W-1:0]         i_in_data,
  output logic                      o_out_valid,
  input  wire logic                 i_out_ready,
  output logic [W-1:0]              o_out_data,
  output logic [$clog2(D):0]        o_level
);
  localparam int AW = $clog2(D);
  localparam logic [AW-1:0] LAST  = AW'(D - 1);
  localparam logic [AW:0]   FULLC = (AW + 1)'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  // Honest flags straight from the occupancy count
  assign o_in_ready  = (count != FULLC);
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign o_level     = count;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage is not reset, only the pointers and the count are
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end

  // Write pointer
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      wr_ptr <= '0;
    else if (push)
      wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
  end

  // Read pointer
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rd_ptr <= '0;
    else if (pop)
      rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
  end

  // Occupancy
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      count <= '0;
    else if (push && !pop)
      count <= count + 1'b1;
    else if (pop && !push)
      count <= count - 1'b1;
  end
endmodule : cbc_fifo

module cbc_top #(
  parameter int FIFO_DEPTH = cbc_pkg::FIFO_DEPTH
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [3:0]    sel;
  logic [7:0]    byte_reg;
  logic [15:0]   crc;
  logic          hold;
  logic          dp_act;
  logic          dp_wr;
  logic [11:0]   dp_addr;
  logic          rd_done;
  logic          addr_take;
  logic          wr_sel;
  logic          wr_ctrl;
  logic          wr_byte;
  logic          rd_result;
  logic          sel_commit;
  logic          sel_legal;
  logic          read_ok;
  logic          fifo_ready;
  logic          fifo_valid;
  logic          pop;
  logic [7:0]    fifo_byte;
  logic [LW-1:0] level;
  logic [2:0]    alg;
  logic [15:0]   result;
  logic [15:0]   next_crc;
  logic [31:0]   next_rdata;

  // Reverse a byte, used on reflected inputs
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i] = d[7-i];
    return r;
  endfunction : rev8

  // Reverse a 16-bit remainder
  function automatic logic [15:0] rev16(input logic [15:0] d);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++)
      r[i] = d[15-i];
    return r;
  endfunction : rev16

  // MSB-first division of one byte; x^16 is the carry out of bit 15
  function automatic logic [15:0] crc_step(input logic [15:0] c_in,
                                           input logic [7:0]  d,
                                           input logic [15:0] poly);
    logic [15:0] c;
    c = c_in ^ {d, 8'h00};
    for (int b = 0; b < 8; b++)
      c = c[15] ? ({c[14:0], 1'b0} ^ poly) : {c[14:0], 1'b0};
    return c;
  endfunction : crc_step

  // Final value as software sees it
  function automatic logic [15:0] crc_final(input logic [15:0] c, input logic [2:0] a);
    logic [15:0] v;
    v = cbc_pkg::ALG_REFL[a] ? rev16(c) : c;
    return v ^ cbc_pkg::ALG_XOR[a];
  endfunction : crc_final

  assign O_HRESP = 1'b0;
  assign alg     = sel[2:0];
  assign result  = crc_final(crc, alg);

  // Bus address phase and decoded data-phase accesses
  assign addr_take = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign wr_sel    = dp_act && dp_wr && (dp_addr == cbc_pkg::ADDR_SELECT);
  assign wr_ctrl   = dp_act && dp_wr && (dp_addr == cbc_pkg::ADDR_CONTROL);
  assign wr_byte   = dp_act && dp_wr && (dp_addr == cbc_pkg::ADDR_BYTE);
  assign rd_result = dp_act && !dp_wr && (dp_addr == cbc_pkg::ADDR_RESULT);

  // Selector waits for queued bytes so the old algorithm finishes them
  assign sel_commit = wr_sel && !fifo_valid;
  assign sel_legal  = !I_HWDATA[cbc_pkg::SEL_RSV_BIT];
  // Result read waits for the queue unless software holds the engine
  assign read_ok    = !(rd_result && fifo_valid && !hold);
  assign pop        = fifo_valid && !hold;

  // Wait states: full queue stalls byte writes, busy engine stalls selector writes and result reads
  always_comb
  begin
    if (!dp_act)
      O_HREADYOUT = 1'b1;
    else if (wr_byte)
      O_HREADYOUT = fifo_ready;
    else if (wr_sel)
      O_HREADYOUT = !fifo_valid;
    else if (dp_wr)
      O_HREADYOUT = 1'b1;
    else
      O_HREADYOUT = rd_done;
  end

  // Data phase tracking
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      dp_act  <= 1'b0;
      dp_wr   <= 1'b0;
      dp_addr <= '0;
    end
    else if (addr_take)
    begin
      dp_act  <= 1'b1;
      dp_wr   <= I_HWRITE;
      dp_addr <= I_HADDR[11:0];
    end
    else if (O_HREADYOUT)
      dp_act <= 1'b0;
  end

  // Read data mux; unmapped offsets read zero
  always_comb
  begin
    next_rdata = '0;
    case (dp_addr)
      cbc_pkg::ADDR_SELECT:
        next_rdata[3:0] = sel;
      cbc_pkg::ADDR_CONTROL:
      begin
        next_rdata[cbc_pkg::HOLD_BIT] = hold;
        next_rdata[cbc_pkg::LEVEL_LSB +: LW] = level;
      end
      cbc_pkg::ADDR_BYTE:
        next_rdata[7:0] = byte_reg;
      cbc_pkg::ADDR_RESULT:
        next_rdata[15:0] = result;
      default:
        next_rdata = '0;
    endcase
  end

  // Reads always take at least one wait state so read data comes from a flop
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rd_done  <= 1'b0;
      O_HRDATA <= '0;
    end
    else if (dp_act && !dp_wr && !rd_done && read_ok)
    begin
      rd_done  <= 1'b1;
      O_HRDATA <= next_rdata;
    end
    else
      rd_done <= 1'b0;
  end

  // Algorithm selector; reserved codes leave everything untouched
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
      sel <= cbc_pkg::SEL_RESET;
    else if (sel_commit && sel_legal)
      sel <= I_HWDATA[3:0];
  end

  // Engine hold bit, lets software park bytes in the queue
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
      hold <= cbc_pkg::HOLD_RESET;
    else if (wr_ctrl)
      hold <= I_HWDATA[cbc_pkg::HOLD_BIT];
  end

  // Last byte written, readable back
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
      byte_reg <= cbc_pkg::BYTE_RESET;
    else if (wr_byte && fifo_ready)
      byte_reg <= I_HWDATA[7:0];
  end

  cbc_fifo #(
    .W (cbc_pkg::BYTE_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_SYS_CLK),
    .i_rst       (I_RST),
    .i_in_valid  (wr_byte),
    .o_in_ready  (fifo_ready),
    .i_in_data   (I_HWDATA[7:0]),
    .o_out_valid (fifo_valid),
    .i_out_ready (!hold),
    .o_out_data  (fifo_byte),
    .o_level     (level)
  );

  // One byte per clock, in write order
  assign next_crc = crc_step(crc,
                             cbc_pkg::ALG_REFL[alg] ? rev8(fifo_byte) : fifo_byte,
                             cbc_pkg::ALG_POLY[alg]);

  // Remainder register; reset value makes the result read 0xffff
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
      crc <= cbc_pkg::CRC_RESET;
    else if (sel_commit && sel_legal)
      crc <= cbc_pkg::ALG_INIT[I_HWDATA[2:0]];
    else if (pop)
      crc <= next_crc;
  end

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);

  sequence s_push_idle;
    wr_byte && fifo_ready && !fifo_valid && !hold;
  endsequence

  // A pipelined second write may refill the queue, so judge the popped byte by level
  sequence s_drain_one;
    ##1 (pop && level == LW'(1));
  endsequence

  chk_byte_fed: assert property (pop |=> crc == crc_step($past(crc),
      cbc_pkg::ALG_REFL[$past(alg)] ? rev8($past(fifo_byte)) : $past(fifo_byte),
      cbc_pkg::ALG_POLY[$past(alg)]))
    else $error("crc did not absorb popped byte");

  chk_sel_reload: assert property (sel_commit && sel_legal
      |=> crc == cbc_pkg::ALG_INIT[sel[2:0]] && sel == $past(I_HWDATA[3:0]))
    else $error("selector write did not load initial value");

  chk_sel_reserved: assert property (sel_commit && !sel_legal
      |=> $stable(crc) && $stable(sel))
    else $error("reserved selector changed state");

  chk_poly_pick: assert property (cbc_pkg::ALG_POLY[alg] ==
      (sel[2] ? 16'h1021 : 16'h8005))
    else $error("wrong polynomial for selector");

  chk_result_fmt: assert property (rd_done && dp_addr == cbc_pkg::ADDR_RESULT
      |-> O_HRDATA[31:16] == 16'h0000 && O_HRDATA[15:0] ==
      ((cbc_pkg::ALG_REFL[alg] ? rev16(crc) : crc) ^ cbc_pkg::ALG_XOR[alg]))
    else $error("result read wrong value");

  chk_read_fresh: assert property (rd_done && dp_addr == cbc_pkg::ADDR_RESULT
      |-> !fifo_valid || hold)
    else $error("result read before queue drained");

  chk_byte_queued: assert property (s_push_idle |-> s_drain_one)
    else $error("byte not processed in one cycle");

  chk_byte_store: assert property (wr_byte && fifo_ready
      |=> byte_reg == $past(I_HWDATA[7:0]) && level != '0)
    else $error("data write not captured");

  chk_reset_vals: assert property ($fell(I_RST)
      |-> sel == cbc_pkg::SEL_RESET && result == 16'hffff && byte_reg == 8'h00)
    else $error("reset values wrong");
endmodule : cbc_top

// *** cbc_top_bench.sv ***
`timescale 1ns/1ps
module cbc_top_bench;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  int          miscompares = 0;
  int          comparisons = 0;
  logic [15:0] rem  = 16'hffff;
  logic [2:0]  code = 3'h4;
  logic [31:0] rd;

  // Expected presets per algorithm code
  localparam logic [15:0] INIT_TAB [8] = '{16'h0000, 16'h0000, 16'hffff, 16'hffff,
                                           16'h0000, 16'hffff, 16'hffff, 16'h0000};
  localparam logic [15:0] XOR_TAB [8]  = '{16'h0000, 16'hffff, 16'hffff, 16'h0000,
                                           16'h0000, 16'h0000, 16'hffff, 16'h0000};
  localparam logic        REFL_TAB [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  // 250 MHz system clock, running before any access
  always #2 clk = ~clk;

  // Single slave, so its ready is the bus ready
  cbc_top #(.FIFO_DEPTH(8)) DUT (
    .I_SYS_CLK   (clk),
    .I_RST       (rst),
    .I_HSEL      (hsel),
    .I_HADDR     (haddr),
    .I_HTRANS    (htrans),
    .I_HWRITE    (hwrite),
    .I_HSIZE     (3'h2),
    .I_HWDATA    (hwdata),
    .I_HREADY    (hready),
    .O_HRDATA    (hrdata),
    .O_HREADYOUT (hready),
    .O_HRESP     (hresp)
  );

  task complete_run;
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait for ready sampled high at a rising edge
  task wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 2000)
      begin
        miscompares++;
        complete_run;
      end
      @(posedge clk);
    end
  endtask : wait_ready

  // One single transfer; read data taken at the closing edge
  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : ahb

  task wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk

  // Reserved codes leave the reference untouched
  task sel(input logic [3:0] c);
    wr(cbc_pkg::ADDR_SELECT, {28'h0, c});
    if (!c[3])
    begin
      code = c[2:0];
      rem  = INIT_TAB[c[2:0]];
    end
  endtask : sel

  // Bitwise reference; reflected presets run a true LSB-first register
  // so the design's input and output reversal are checked, not mirrored
  task push(input logic [31:0] d);
    logic [15:0] poly;
    logic [15:0] rpoly;
    poly  = code[2] ? 16'h1021 : 16'h8005;
    rpoly = {<<{poly}};
    if (REFL_TAB[code])
    begin
      rem = rem ^ {8'h00, d[7:0]};
      for (int i = 0; i < 8; i++)
        rem = rem[0] ? ((rem >> 1) ^ rpoly) : (rem >> 1);
    end
    else
    begin
      rem = rem ^ {d[7:0], 8'h00};
      for (int i = 0; i < 8; i++)
        rem = rem[15] ? ((rem << 1) ^ poly) : (rem << 1);
    end
    wr(cbc_pkg::ADDR_BYTE, d);
  endtask : push

  // Reflected register already holds its bits in output order;
  // all initial values are palindromes, so one start value serves both forms
  function automatic logic [31:0] exp_crc();
    return {16'h0, rem ^ XOR_TAB[code]};
  endfunction : exp_crc

  task t_reset_values;
    rdchk(cbc_pkg::ADDR_SELECT, 32'h4);
    rdchk(cbc_pkg::ADDR_BYTE, 32'h0);
    rdchk(cbc_pkg::ADDR_RESULT, 32'hffff);
  endtask : t_reset_values

  // Every preset over the same eight-byte message
  task t_all_algorithms;
    for (int c = 0; c < 8; c++)
    begin
      sel(c[3:0]);
      rdchk(cbc_pkg::ADDR_SELECT, c);
      rdchk(cbc_pkg::ADDR_RESULT, exp_crc());
      for (int i = 0; i < 8; i++)
        push(i * 32'h11);
      rdchk(cbc_pkg::ADDR_RESULT, exp_crc());
      rdchk(cbc_pkg::ADDR_BYTE, 32'h77);
    end
  endtask : t_all_algorithms

  // Upper data bits must not reach the divider
  task t_upper_bits;
    sel(4'h6);
    push(32'hdeadbe5a);
    rdchk(cbc_pkg::ADDR_BYTE, 32'h5a);
    push(32'h000001a5);
    rdchk(cbc_pkg::ADDR_RESULT, exp_crc());
  endtask : t_upper_bits

  task t_reserved_select;
    for (int c = 8; c < 16; c++)
      sel(c[3:0]);
    rdchk(cbc_pkg::ADDR_SELECT, 32'h6);
    rdchk(cbc_pkg::ADDR_RESULT, exp_crc());
  endtask : t_reserved_select

  // Hold the engine, fill the queue, then release and read at once
  task t_queue_fill;
    sel(4'h1);
    wr(cbc_pkg::ADDR_CONTROL, 32'h1);
    for (int i = 0; i < 8; i++)
      push(32'h30 + i);
    rdchk(cbc_pkg::ADDR_CONTROL, 32'h801);
    wr(cbc_pkg::ADDR_CONTROL, 32'h0);
    rdchk(cbc_pkg::ADDR_RESULT, exp_crc());
    rdchk(cbc_pkg::ADDR_CONTROL, 32'h0);
  endtask : t_queue_fill

  // Unmapped and read-only places ignore writes
  task t_unmapped;
    rdchk(12'h010, 32'h0);
    wr(12'h010, 32'hffffffff);
    wr(cbc_pkg::ADDR_RESULT, 32'h1234);
    rdchk(12'h010, 32'h0);
    rdchk(cbc_pkg::ADDR_RESULT, exp_crc());
    rdchk(cbc_pkg::ADDR_SELECT, 32'h1);
  endtask : t_unmapped

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset_values;
    t_all_algorithms;
    t_upper_bits;
    t_reserved_select;
    t_queue_fill;
    t_unmapped;
    complete_run;
  end
endmodule : cbc_top_bench
